// >>> logic/system_output_voltage_control_defines.svh
// constants for the system output voltage control register
// Functional notes
// - bit 7 high enables the switcher; low disables it and pulls the rail low
// - bits 6:5 select range: 01 gives 1.3-2.8 V, 11 gives 1.8-3.3 V, 10 forbidden
// - bits 4:1 are a binary code weighing 800, 400, 200, 100 mV in ranges 01 and 11
// - range 01 target is 1.30 V plus 100 mV per code step
// - range 11 target is 1.8 V at code 0 up to 3.3 V at code 15
// - range 00 is the low range from a fixed table, 1.1 V and 1.2 V first
// - reset value is 1010 1010, enabled, range 01, code 0101, 1.8 V
`ifndef SYSTEM_OUTPUT_VOLTAGE_CONTROL_DEFINES_SVH
`define SYSTEM_OUTPUT_VOLTAGE_CONTROL_DEFINES_SVH
`define SVO_OFFSET      8'h06
`define SVO_RESET       8'hAA
`define SVO_EN_BIT      7
`define SVO_SEL_HI      6
`define SVO_SEL_LO      5
`define SVO_CODE_HI     4
`define SVO_CODE_LO     1
`define SVO_WMASK       8'hFE
`define SVO_MV_STEP     16'h0064
`define SVO_MV_R01_BASE 16'h0514
`define SVO_MV_R11_BASE 16'h0708
`endif

// >>> logic/system_output_voltage_control_pkg.sv
// types for the system output voltage control register
`default_nettype none
package system_output_voltage_control_pkg;
   typedef enum logic [1:0] {
      RANGE_LOW  = 2'h0,
      RANGE_MID  = 2'h1,
      RANGE_BAD  = 2'h2,
      RANGE_HIGH = 2'h3
   } output_range_t;
endpackage
`default_nettype wire

// >>> logic/system_output_voltage_control.sv
// system output voltage control register and target decoder
`timescale 1ns/1ps
`default_nettype none
`include "system_output_voltage_control_defines.svh"
module system_output_voltage_control (
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   input  wire logic [7:0]  addr,
   input  wire logic [7:0]  wdata,
   output var  logic [7:0]  rdata,
   output var  logic        rd_valid,
   output var  logic        regulator_output_enable,
   output var  logic        switcher_output_pulldown,
   output var  logic [1:0]  output_range_select,
   output var  logic [3:0]  output_voltage_code,
   output var  logic [15:0] target_mv,
   output var  logic        range_invalid
);
   // ==========================================
   // register
   logic [7:0]  ctrl_reg;
   logic [7:0]  ctrl_next;
   logic        hit;
   logic [15:0] target_next;
   logic [3:0]  code;
   assign hit  = (addr == `SVO_OFFSET);
   assign code = ctrl_next[`SVO_CODE_HI:`SVO_CODE_LO];
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_en && hit) begin
         ctrl_next = wdata & `SVO_WMASK;
      end
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_reg <= `SVO_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end
   // ==========================================
   // read port
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rdata    <= 8'h00;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= rd_en;
         if (rd_en) begin
            rdata <= hit ? (ctrl_reg & `SVO_WMASK) : 8'h00;
         end
      end
   end
   // ==========================================
   // target decode
   function automatic logic [15:0] low_table(input logic [3:0] c);
      logic [15:0] v;
      v = 16'h0000;
      unique case (c)
         4'h0: v = 16'h044C;
         4'h1: v = 16'h04B0;
         4'h2: v = 16'h04E2;
         4'h3: v = 16'h0535;
         4'h4: v = 16'h0589;
         4'h5: v = 16'h05DC;
         4'h6: v = 16'h062F;
         4'h7: v = 16'h0683;
         4'h8: v = 16'h06D6;
         4'h9: v = 16'h0729;
         4'hA: v = 16'h077D;
         4'hB: v = 16'h07D0;
         4'hC: v = 16'h0823;
         4'hD: v = 16'h0877;
         4'hE: v = 16'h08CA;
         4'hF: v = 16'h091D;
      endcase
      return v;
   endfunction
   always_comb begin
      target_next = 16'h0000;
      unique case (system_output_voltage_control_pkg::output_range_t'(ctrl_next[`SVO_SEL_HI:`SVO_SEL_LO]))
         system_output_voltage_control_pkg::RANGE_LOW:  target_next = low_table(code);
         system_output_voltage_control_pkg::RANGE_MID:  target_next = `SVO_MV_R01_BASE
                                    + 16'({12'h000, code} * `SVO_MV_STEP);
         system_output_voltage_control_pkg::RANGE_HIGH: target_next = `SVO_MV_R11_BASE
                                    + 16'({12'h000, code} * `SVO_MV_STEP);
         system_output_voltage_control_pkg::RANGE_BAD:  target_next = 16'h0000;
      endcase
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         regulator_output_enable  <= 1'b1;
         switcher_output_pulldown <= 1'b0;
         output_range_select      <= 2'h1;
         output_voltage_code      <= 4'h5;
         target_mv                <= `SVO_MV_R11_BASE;
         range_invalid            <= 1'b0;
      end else begin
         regulator_output_enable  <= ctrl_next[`SVO_EN_BIT];
         switcher_output_pulldown <= !ctrl_next[`SVO_EN_BIT];
         output_range_select      <= ctrl_next[`SVO_SEL_HI:`SVO_SEL_LO];
         output_voltage_code      <= code;
         target_mv                <= target_next;
         range_invalid            <= (ctrl_next[`SVO_SEL_HI:`SVO_SEL_LO] == 2'h2);
      end
   end
   // ==========================================
   // sequences
   sequence seq_write_hit;
      wr_en && hit;
   endsequence
   sequence seq_read_hit;
      rd_en && hit;
   endsequence
   sequence seq_read_miss;
      rd_en && !hit;
   endsequence
   sequence seq_read_req;
      rd_en;
   endsequence
   sequence seq_mid_range;
      output_range_select == 2'h1;
   endsequence
   sequence seq_high_range;
      output_range_select == 2'h3;
   endsequence
   sequence seq_bad_range;
      range_invalid;
   endsequence
   // ==========================================
   // checks
   chk_enable_pulldown: assert property (
      @(posedge core_clk) disable iff (!resetn)
      regulator_output_enable != switcher_output_pulldown)
      else $error("enable and pulldown agree");
   chk_enable_follows: assert property (
      @(posedge core_clk) disable iff (!resetn)
      seq_write_hit |=> regulator_output_enable == $past(wdata[`SVO_EN_BIT]))
      else $error("enable did not follow write");
   chk_enable_reg: assert property (
      @(posedge core_clk) disable iff (!resetn)
      regulator_output_enable == ctrl_reg[`SVO_EN_BIT])
      else $error("enable differs from register");

   chk_bit0_zero: assert property (
      @(posedge core_clk) disable iff (!resetn)
      rd_valid |-> rdata[0] == 1'b0)
      else $error("bit 0 read as one");
   chk_bit0_stored: assert property (
      @(posedge core_clk) disable iff (!resetn)
      ctrl_reg[0] == 1'b0)
      else $error("bit 0 stored as one");
   chk_read_pulse: assert property (
      @(posedge core_clk) disable iff (!resetn)
      seq_read_req |=> rd_valid)
      else $error("read valid missing");
   chk_read_data: assert property (
      @(posedge core_clk) disable iff (!resetn)
      seq_read_hit |=> rdata == ($past(ctrl_reg) & `SVO_WMASK))
      else $error("read data wrong");
   chk_read_miss: assert property (
      @(posedge core_clk) disable iff (!resetn)
      seq_read_miss |=> rdata == 8'h00)
      else $error("unmapped read not zero");

   chk_range_follows: assert property (
      @(posedge core_clk) disable iff (!resetn)
      seq_write_hit |=> output_range_select == $past(wdata[`SVO_SEL_HI:`SVO_SEL_LO]))
      else $error("range did not follow write");
   chk_range_reg: assert property (
      @(posedge core_clk) disable iff (!resetn)
      output_range_select == ctrl_reg[`SVO_SEL_HI:`SVO_SEL_LO])
      else $error("range differs from register");
   chk_bad_flag: assert property (
      @(posedge core_clk) disable iff (!resetn)
      range_invalid == (output_range_select == 2'h2))
      else $error("invalid range flag wrong");
   chk_bad_target: assert property (
      @(posedge core_clk) disable iff (!resetn)
      seq_bad_range |-> target_mv == 16'h0000)
      else $error("invalid range target not zero");

   chk_code_follows: assert property (
      @(posedge core_clk) disable iff (!resetn)
      seq_write_hit |=> output_voltage_code == $past(wdata[`SVO_CODE_HI:`SVO_CODE_LO]))
      else $error("code did not follow write");
   chk_code_reg: assert property (
      @(posedge core_clk) disable iff (!resetn)
      output_voltage_code == ctrl_reg[`SVO_CODE_HI:`SVO_CODE_LO])
      else $error("code differs from register");
   chk_code_weight: assert property (
      @(posedge core_clk) disable iff (!resetn)
      (output_range_select == 2'h1 && output_voltage_code == 4'h8) |-> target_mv == 16'h0834)
      else $error("code bit 4 weight wrong");
   chk_code_lsb: assert property (
      @(posedge core_clk) disable iff (!resetn)
      (output_range_select == 2'h1 && output_voltage_code == 4'h1) |-> target_mv == 16'h0578)
      else $error("code bit 1 weight wrong");

   chk_mid_range: assert property (
      @(posedge core_clk) disable iff (!resetn)
      seq_mid_range |-> target_mv == 16'h0514 + output_voltage_code * 16'h0064)
      else $error("mid range target wrong");
   chk_high_range: assert property (
      @(posedge core_clk) disable iff (!resetn)
      seq_high_range |-> target_mv == 16'h0708 + output_voltage_code * 16'h0064)
      else $error("high range target wrong");
   chk_high_top: assert property (
      @(posedge core_clk) disable iff (!resetn)
      (output_range_select == 2'h3 && output_voltage_code == 4'hF) |-> target_mv == 16'h0CE4)
      else $error("high range top wrong");

   chk_low_first: assert property (
      @(posedge core_clk) disable iff (!resetn)
      (output_range_select == 2'h0 && output_voltage_code == 4'h1) |-> target_mv == 16'h04B0)
      else $error("low range code 1 wrong");
   chk_low_zero: assert property (
      @(posedge core_clk) disable iff (!resetn)
      (output_range_select == 2'h0 && output_voltage_code == 4'h0) |-> target_mv == 16'h044C)
      else $error("low range code 0 wrong");
endmodule // system_output_voltage_control
`default_nettype wire

// >>> test/system_output_voltage_control_bench.sv
// self-checking bench for the output voltage control register
`timescale 1ns/1ps
`default_nettype none
module system_output_voltage_control_bench;
   logic        core_clk = 1'b0;
   logic        resetn   = 1'b0;
   logic        wr_en    = 1'b0;
   logic        rd_en    = 1'b0;
   logic [7:0]  addr     = 8'h06;
   logic [7:0]  wdata    = 8'h00;
   logic [7:0]  rdata;
   logic        rd_valid, regulator_output_enable, switcher_output_pulldown, range_invalid;
   logic [1:0]  output_range_select, s;
   logic [3:0]  output_voltage_code, c;
   logic [15:0] target_mv, e;
   int          fail_count = 0;
   int          comparisons = 0;
   logic [15:0] low_mv [16] = '{16'h044C, 16'h04B0, 16'h04E2, 16'h0535, 16'h0589, 16'h05DC,
      16'h062F, 16'h0683, 16'h06D6, 16'h0729, 16'h077D, 16'h07D0, 16'h0823, 16'h0877,
      16'h08CA, 16'h091D};
   system_output_voltage_control dut_u (.core_clk, .resetn, .wr_en, .rd_en, .addr, .wdata,
      .rdata, .rd_valid, .regulator_output_enable, .switcher_output_pulldown,
      .output_range_select, .output_voltage_code, .target_mv, .range_invalid);
   // ==========================================
   // clock, compare and bus tasks
   initial begin
      forever #10 core_clk = ~core_clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      {wr_en, addr, wdata} = {1'b1, a, d};
      @(negedge core_clk);
      wr_en = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      @(negedge core_clk);
      {rd_en, addr} = {1'b1, a};
      @(negedge core_clk);
      rd_en = 1'b0;
      chk(rd_valid, 16'h0001);
      chk(rdata, x);
      @(negedge core_clk);
      chk(rd_valid, 16'h0000);
      chk(rdata, x);
   endtask
   task automatic wrap_up;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ==========================================
   // watchdog
   initial begin
      #50000;
      fail_count++;
      wrap_up;
   end
   // ==========================================
   // tests
   initial begin
      repeat (10) @(negedge core_clk);
      resetn = 1'b1;
      chk({regulator_output_enable, switcher_output_pulldown, output_range_select,
         output_voltage_code}, 16'h0095);
      chk(target_mv, 16'h0708);
      rd(8'h06, 8'hAA);
      for (int i = 0; i < 48; i++) begin
         s = (i < 32) ? i[5:4] : 2'h3;
         c = i[3:0];
         e = (s == 2'h0) ? low_mv[c] : ((s == 2'h1) ? 16'h0514 : 16'h0708) + 16'h0064 * c;
         wr(8'h06, {1'b1, s, c, 1'b1});
         chk(target_mv, e);
         chk({regulator_output_enable, switcher_output_pulldown, output_range_select,
            output_voltage_code, range_invalid}, {2'h2, s, c, 1'b0});
         rd(8'h06, {1'b1, s, c, 1'b0});
      end
      wr(8'h06, 8'h5A);
      chk({regulator_output_enable, switcher_output_pulldown, range_invalid}, 16'h0003);
      chk(target_mv, 16'h0000);
      wr(8'h07, 8'hFF);
      rd(8'h06, 8'h5A);
      rd(8'h07, 8'h00);
      @(negedge core_clk);
      resetn = 1'b0;
      @(negedge core_clk);
      chk({regulator_output_enable, output_range_select, output_voltage_code}, 16'h0055);
      chk({switcher_output_pulldown, range_invalid, rd_valid}, 16'h0000);
      chk(target_mv, 16'h0708);
      resetn = 1'b1;
      rd(8'h06, 8'hAA);
      wrap_up;
   end
endmodule // system_output_voltage_control_bench
`default_nettype wire
